// >>> test_windowed_halt_aware_watchdog.sv
// Purpose: self-checking bench for the halt-aware watchdog
// Assumes: 10 MHz clock, strobe register port
// Notes: directed sequences only
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module test_windowed_halt_aware_watchdog;
    import wdgwh_pkg::*;
    logic sys_clk_i, rst_i, wr_i, rd_i, hw_watchdog_i, halt_reset_option_i;
    logic timebase_irq_enable_i, long_wake_i, was_active_halt_i;
    logic halt_exec_i, ext_irq_i, osc_irq_i, slow_mode_i, wait_mode_i;
    logic [7:0] addr_i, wdata_i, rdata_o;
    logic [1:0] timebase_select_i;
    logic reset_pin_n_o, chip_reset_o, counting_o;
    logic [5:0] tb_msb_o, tb_lsb_o;
    logic [5:0] msb_t [4] = '{6'h04, 6'h08, 6'h14, 6'h31};
    logic [5:0] lsb_t [4] = '{6'h3b, 6'h35, 6'h23, 6'h36};
    int n_fail = 0;
    int cmp_count = 0;
    int n;
    wdgwh_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .hw_watchdog_i(hw_watchdog_i),
        .halt_reset_option_i(halt_reset_option_i),
        .timebase_irq_enable_i(timebase_irq_enable_i),
        .timebase_select_i(timebase_select_i), .long_wake_i(long_wake_i),
        .was_active_halt_i(was_active_halt_i), .halt_exec_i(halt_exec_i),
        .ext_irq_i(ext_irq_i), .osc_irq_i(osc_irq_i),
        .slow_mode_i(slow_mode_i), .wait_mode_i(wait_mode_i),
        .reset_pin_n_o(reset_pin_n_o), .chip_reset_o(chip_reset_o),
        .counting_o(counting_o), .tb_msb_o(tb_msb_o), .tb_lsb_o(tb_lsb_o));
    //////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    task automatic do_rst(input logic ah);
        was_active_halt_i <= ah;
        rst_i <= 1'b1;
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        // let the one-cycle wake step after release pass before any request
        repeat (2) @(posedge sys_clk_i);
    endtask
    task automatic wr(input logic [7:0] d);
        addr_i <= WDGWH_CTRL_ADDR;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        `CHK(rdata_o, e)
        @(posedge sys_clk_i);
    endtask
    // s: 0 counting, 1 chip reset, 2 reset pin; leaves mid-cycle
    task automatic wait_on(input int s, input logic v, input int lim);
        #1;
        n = 0;
        while ((s == 0 ? counting_o : s == 1 ? chip_reset_o : reset_pin_n_o)
               !== v && n < lim) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
    endtask
    task automatic strobe_halt();
        halt_exec_i <= 1'b1;
        @(posedge sys_clk_i);
        halt_exec_i <= 1'b0;
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk_i);
        n_fail++;
        print_verdict();
    end
    //////////////////////////////////////////////////////////////////////
    initial begin
        {rst_i, wr_i, rd_i, hw_watchdog_i, halt_reset_option_i} = '0;
        {timebase_irq_enable_i, long_wake_i, was_active_halt_i} = '0;
        {halt_exec_i, ext_irq_i, osc_irq_i, slow_mode_i, wait_mode_i} = '0;
        {addr_i, wdata_i, timebase_select_i} = '0;
        do_rst(1'b0);
        rd(WDGWH_CTRL_ADDR, 8'h7f);
        rd(8'h2b, 8'h00);
        for (int i = 0; i < 4; i++) begin
            timebase_select_i <= 2'(i);
            repeat (2) @(posedge sys_clk_i);
            #1;
            `CHK({tb_msb_o, tb_lsb_o}, {msb_t[i], lsb_t[i]})
            @(posedge sys_clk_i);
        end
        wr(8'h45);
        rd(WDGWH_CTRL_ADDR, 8'h45);
        wr(8'hc1);
        rd(WDGWH_CTRL_ADDR, 8'hc1);
        wr(8'h41);
        rd(WDGWH_CTRL_ADDR, 8'hc1);
        slow_mode_i <= 1'b1;
        wait_mode_i <= 1'b1;
        wr(8'hc0);
        wait_on(2, 1'b0, 17000);
        `CHK(chip_reset_o, 1'b1)
        wait_on(2, 1'b1, 20);
        `CHK(n, 5)
        @(posedge sys_clk_i);
        {slow_mode_i, wait_mode_i} <= 2'b00;
        hw_watchdog_i <= 1'b1;
        halt_reset_option_i <= 1'b1;
        do_rst(1'b0);
        strobe_halt();
        wait_on(1, 1'b1, 3);
        `CHK(chip_reset_o, 1'b1)
        @(posedge sys_clk_i);
        {hw_watchdog_i, halt_reset_option_i} <= 2'b00;
        do_rst(1'b0);
        rd(WDGWH_CTRL_ADDR, 8'h7f);
        wr(8'hff);
        strobe_halt();
        wait_on(0, 1'b0, 16400);
        `CHK(chip_reset_o, 1'b0)
        @(posedge sys_clk_i);
        rd(WDGWH_CTRL_ADDR, 8'hfe);
        ext_irq_i <= 1'b1;
        @(posedge sys_clk_i);
        ext_irq_i <= 1'b0;
        wait_on(0, 1'b1, 300);
        `CHK(n >= 250 && n <= 260, 1'b1)
        @(posedge sys_clk_i);
        timebase_irq_enable_i <= 1'b1;
        strobe_halt();
        wait_on(0, 1'b0, 3);
        `CHK(counting_o, 1'b0)
        @(posedge sys_clk_i);
        osc_irq_i <= 1'b1;
        @(posedge sys_clk_i);
        osc_irq_i <= 1'b0;
        wait_on(0, 1'b1, 2);
        `CHK(counting_o, 1'b1)
        @(posedge sys_clk_i);
        long_wake_i <= 1'b1;
        do_rst(1'b1);
        wait_on(0, 1'b1, 5000);
        `CHK(n >= 4090 && n <= 4100, 1'b1)
        print_verdict();
    end
endmodule

// >>> wdgwh_asserts.sv
// Purpose: port-level checker for the halt-aware watchdog
// Assumes: single clock domain, rst_i async active high
// Notes: bound into wdgwh_top at the foot of this file
`timescale 1ns/1ps
module wdgwh_asserts
    import wdgwh_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // straps and events
    input wire logic hw_watchdog_i,
    input wire logic halt_reset_option_i,
    input wire logic timebase_irq_enable_i,
    input wire logic [1:0] timebase_select_i,
    input wire logic halt_exec_i,
    input wire logic osc_irq_i,
    // outputs
    input wire logic reset_pin_n_o,
    input wire logic chip_reset_o,
    input wire logic counting_o,
    input wire logic [5:0] tb_msb_o,
    input wire logic [5:0] tb_lsb_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    //////////////////////////////////////////////////////////////////////
    a_pin_len: assert property ($fell(reset_pin_n_o) |->
        !reset_pin_n_o [*5] ##1 reset_pin_n_o) else $error("pin pulse");
    a_chip_one: assert property (chip_reset_o |=> !chip_reset_o)
        else $error("chip reset not one cycle");
    a_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data outside read");
    a_rd_unmapped: assert property (rd_i && addr_i != WDGWH_CTRL_ADDR
        |=> rdata_o == 8'h00) else $error("unmapped read");
    a_act_sticky: assert property ((wr_i && addr_i == WDGWH_CTRL_ADDR
        && wdata_i[7]) ##1 (rd_i && addr_i == WDGWH_CTRL_ADDR)
        |=> rdata_o[7]) else $error("activate lost");
    a_halt_reset: assert property (halt_exec_i && halt_reset_option_i
        && !timebase_irq_enable_i && hw_watchdog_i |-> ##[1:2]
        chip_reset_o) else $error("halt reset missing");
    a_plain_halt: assert property (halt_exec_i && !halt_reset_option_i
        && !timebase_irq_enable_i |=> !chip_reset_o [*2])
        else $error("plain halt reset");
    a_ahalt_stop: assert property (halt_exec_i && timebase_irq_enable_i
        |-> ##[1:2] !counting_o) else $error("active halt runs");
    a_ahalt_wake: assert property (osc_irq_i && timebase_irq_enable_i
        && !counting_o && !halt_exec_i |-> ##[1:2] counting_o)
        else $error("active halt wake slow");
    a_tb_const: assert property (timebase_select_i == 2'h3
        |=> tb_msb_o == 6'h31 && tb_lsb_o == 6'h36) else $error("tb const");
endmodule

bind wdgwh_top wdgwh_asserts u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .hw_watchdog_i(hw_watchdog_i),
    .halt_reset_option_i(halt_reset_option_i),
    .timebase_irq_enable_i(timebase_irq_enable_i),
    .timebase_select_i(timebase_select_i), .halt_exec_i(halt_exec_i),
    .osc_irq_i(osc_irq_i), .reset_pin_n_o(reset_pin_n_o),
    .chip_reset_o(chip_reset_o), .counting_o(counting_o),
    .tb_msb_o(tb_msb_o), .tb_lsb_o(tb_lsb_o));

// >>> wdgwh_pkg.sv
// Purpose: constants for the windowed halt-aware watchdog
// Assumes: 10 MHz system clock used as the oscillator clock
// Notes: register offsets, reset values and timing counts
package wdgwh_pkg;
    localparam logic [7:0] WDGWH_CTRL_ADDR = 8'h2a;
    localparam logic [7:0] WDGWH_CTRL_RESET = 8'h7f;
    localparam int WDGWH_ACT_BIT = 7;
    localparam int WDGWH_TOP_BIT = 6;
    localparam int WDGWH_PRESCALE = 16384;
    localparam int WDGWH_PRE_W = 14;
    localparam logic [13:0] WDGWH_PRE_LAST = 14'h3fff;
    localparam logic [6:0] WDGWH_EXPIRE_FROM = 7'h40;
    localparam int WDGWH_CLK_MHZ = 10;
    localparam int WDGWH_PULSE_NS = 500;
    localparam int WDGWH_PULSE_CYC = (WDGWH_PULSE_NS * WDGWH_CLK_MHZ) / 1000;
    localparam logic [12:0] WDGWH_WAKE_SHORT = 13'h0100;
    localparam logic [12:0] WDGWH_WAKE_LONG = 13'h1000;
    localparam logic [1:0] WDGWH_TB_2MS = 2'h0;
    localparam logic [1:0] WDGWH_TB_4MS = 2'h1;
    localparam logic [1:0] WDGWH_TB_10MS = 2'h2;
    localparam logic [1:0] WDGWH_TB_25MS = 2'h3;
    localparam logic [5:0] WDGWH_MSB_TB0 = 6'h04;
    localparam logic [5:0] WDGWH_MSB_TB1 = 6'h08;
    localparam logic [5:0] WDGWH_MSB_TB2 = 6'h14;
    localparam logic [5:0] WDGWH_MSB_TB3 = 6'h31;
    localparam logic [5:0] WDGWH_LSB_TB0 = 6'h3b;
    localparam logic [5:0] WDGWH_LSB_TB1 = 6'h35;
    localparam logic [5:0] WDGWH_LSB_TB2 = 6'h23;
    localparam logic [5:0] WDGWH_LSB_TB3 = 6'h36;
    typedef enum logic [1:0] {
        WDGWH_RUN = 2'b00,
        WDGWH_LAST = 2'b01,
        WDGWH_FROZEN = 2'b11,
        WDGWH_WAKE = 2'b10
    } wdgwh_state_e;
endpackage

// >>> wdgwh_pulse.sv
// Purpose: stretches a one-cycle trigger into a fixed-length low pulse
// Assumes: trigger is one cycle, synchronous to sys_clk_i
// Notes: output is registered
`timescale 1ns/1ps
module wdgwh_pulse (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // trigger and pulse
    input wire logic trig_i,
    output logic rst_n_o
);
    import wdgwh_pkg::*;
    localparam int CW = 4;
    logic [CW-1:0] left;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            left <= '0;
        end else if (trig_i) begin
            left <= CW'(WDGWH_PULSE_CYC);
        end else if (left != '0) begin
            left <= left - CW'(1);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rst_n_o <= 1'b1;
        end else begin
            rst_n_o <= !(trig_i || left > CW'(1));
        end
    end
endmodule

// >>> wdgwh_top.sv
// Purpose: free-running 7-bit watchdog with halt-mode handling
// Assumes: chip reset arrives on rst_i; option bits are static straps
// Notes: register port is plain strobe style, read data one cycle later
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - max timeout adds prescaler phase once, on first decrement
// - timeout divisions truncate downward
// - plain halt: one more decrement, then freeze
// - external wake resumes after 256/4096 clocks
// - reset ends halt, watchdog off unless hardware
// - halt with halt-reset option resets chip if watchdog active, timebase irq off
// - active-halt freezes counter, interrupt resumes at once
// - reset after active-halt delays count restart
// - slow and wait leave counter running
// - hardware option forces watchdog always active
// - activate bit set by software, cleared by reset
// - count decrements per 16384 clocks, expire 40h->3Fh
// - control register resets to 7Fh
// - timebase select picks MSB and LSB constants
// - expiry drives reset pin low about 500ns
module wdgwh_top (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // option straps and clock-controller state
    input wire logic hw_watchdog_i,
    input wire logic halt_reset_option_i,
    input wire logic timebase_irq_enable_i,
    input wire logic [1:0] timebase_select_i,
    input wire logic long_wake_i,
    input wire logic was_active_halt_i,
    // cpu power events
    input wire logic halt_exec_i,
    input wire logic ext_irq_i,
    input wire logic osc_irq_i,
    input wire logic slow_mode_i,
    input wire logic wait_mode_i,
    // outputs
    output logic reset_pin_n_o,
    output logic chip_reset_o,
    output logic counting_o,
    output logic [5:0] tb_msb_o,
    output logic [5:0] tb_lsb_o
);
    import wdgwh_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // state
    logic watchdog_activate;
    logic [6:0] timeout_count;
    logic [WDGWH_PRE_W-1:0] prescale;
    logic tick;
    wdgwh_state_e state;
    wdgwh_state_e next_state;
    logic [12:0] wake_cnt;
    logic ctrl_wr;
    logic active;
    logic expire;
    logic halt_trig;
    logic trig;
    logic boot_pending;
    logic running;

    assign ctrl_wr = wr_i && (addr_i == WDGWH_CTRL_ADDR);
    assign active = watchdog_activate || hw_watchdog_i;
    assign tick = (prescale == WDGWH_PRE_LAST);
    assign running = (state == WDGWH_RUN) || (state == WDGWH_LAST);
    // slow and wait have no input into the counting path
    assign expire = active && running && tick && !ctrl_wr
        && (timeout_count == WDGWH_EXPIRE_FROM);
    assign halt_trig = halt_exec_i && running && active
        && !timebase_irq_enable_i && halt_reset_option_i;
    // a write that clears the top count bit triggers nothing; reset waits for the tick that takes the count from 40h to 3Fh
    assign trig = expire || halt_trig;

    //////////////////////////////////////////////////////////////////////////
    // prescaler: phase unknown to software, which gives the timeout window
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prescale <= '0;
        end else if (running) begin
            prescale <= prescale + WDGWH_PRE_W'(1);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // activation bit
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            watchdog_activate <= WDGWH_CTRL_RESET[WDGWH_ACT_BIT];
        end else if (ctrl_wr && wdata_i[WDGWH_ACT_BIT]) begin
            watchdog_activate <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // counter
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            timeout_count <= WDGWH_CTRL_RESET[6:0];
        end else if (ctrl_wr) begin
            timeout_count <= wdata_i[6:0];
        end else if (running && tick) begin
            timeout_count <= timeout_count - 7'h01;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // halt-mode sequencing
    always_comb begin
        next_state = state;
        case (state)
            WDGWH_RUN: begin
                if (halt_exec_i && !halt_trig) begin
                    if (timebase_irq_enable_i) begin
                        next_state = WDGWH_FROZEN;
                    end else begin
                        next_state = WDGWH_LAST;
                    end
                end
            end
            WDGWH_LAST: begin
                if (ext_irq_i) begin
                    next_state = WDGWH_WAKE;
                end else if (tick) begin
                    next_state = WDGWH_FROZEN;
                end
            end
            WDGWH_FROZEN: begin
                if (ext_irq_i && !timebase_irq_enable_i) begin
                    next_state = WDGWH_WAKE;
                end else if ((ext_irq_i || osc_irq_i)
                        && timebase_irq_enable_i) begin
                    next_state = WDGWH_RUN;
                end
            end
            WDGWH_WAKE: begin
                if (wake_cnt == 13'h0001) begin
                    next_state = WDGWH_RUN;
                end
            end
            default: next_state = WDGWH_RUN;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= WDGWH_RUN;
        end else if (boot_pending) begin
            state <= WDGWH_WAKE;
        end else begin
            state <= next_state;
        end
    end

    // a reset leaving active-halt delays the restart; caught after release
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            boot_pending <= 1'b1;
        end else begin
            boot_pending <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_cnt <= '0;
        end else if (boot_pending) begin
            wake_cnt <= was_active_halt_i
                ? (long_wake_i ? WDGWH_WAKE_LONG : WDGWH_WAKE_SHORT)
                : 13'h0001;
        end else if (state != WDGWH_WAKE && next_state == WDGWH_WAKE) begin
            wake_cnt <= long_wake_i ? WDGWH_WAKE_LONG
                : WDGWH_WAKE_SHORT;
        end else if (wake_cnt != '0) begin
            wake_cnt <= wake_cnt - 13'h0001;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // timebase constants for software timeout estimates
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tb_msb_o <= WDGWH_MSB_TB0;
            tb_lsb_o <= WDGWH_LSB_TB0;
        end else begin
            case (timebase_select_i)
                WDGWH_TB_2MS: begin
                    tb_msb_o <= WDGWH_MSB_TB0;
                    tb_lsb_o <= WDGWH_LSB_TB0;
                end
                WDGWH_TB_4MS: begin
                    tb_msb_o <= WDGWH_MSB_TB1;
                    tb_lsb_o <= WDGWH_LSB_TB1;
                end
                WDGWH_TB_10MS: begin
                    tb_msb_o <= WDGWH_MSB_TB2;
                    tb_lsb_o <= WDGWH_LSB_TB2;
                end
                default: begin
                    tb_msb_o <= WDGWH_MSB_TB3;
                    tb_lsb_o <= WDGWH_LSB_TB3;
                end
            endcase
        end
    end
    // window bounds use truncating integer division of these constants

    //////////////////////////////////////////////////////////////////////////
    // read port and status
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i && addr_i == WDGWH_CTRL_ADDR) begin
            rdata_o <= {watchdog_activate, timeout_count};
        end else begin
            rdata_o <= 8'h00;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            counting_o <= 1'b0;
            chip_reset_o <= 1'b0;
        end else begin
            counting_o <= running;
            chip_reset_o <= trig;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // reset pin pulse
    wdgwh_pulse u_pulse (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .trig_i(trig),
        .rst_n_o(reset_pin_n_o)
    );
endmodule
